//--- pkg/dcs_pkg.sv
// constants and types for the debug control and status register pair
//
// What this block does
// - debug_enable bit gates background mode entry
// - special single chip reset sets debug_enable
// - debug_mode_active set on entry, cleared on exit
// - special single chip reset sets debug_mode_active
// - continue_in_stop selects stop clocks when enabled
// - writes to continue_in_stop ignored in stop
// - steal bit picks free-cycle wait or next cycle with ack on; with ack off accesses always take the next cycle
// - clock switch sets once, cleared only by reset
// - unsecured_status follows security, not writable
// - erase pending set by command, cleared on done
// - other low flags clear only by writing one
// - host_overrun_flag cleared only by sync
// - failed commands, and commands setting a flag other than ram write fault, get long acknowledge
// - first acknowledge after wait or stop is long
// - pin overrun defers long acknowledge until byte received
// - unimplemented opcode illegal flag gives no long acknowledge
// - wait flag clear blocked while in wait
// - stop flag set only when enabled, clear outside stop
// - ram write fault flag set on double fault
// - overrun set on early command, suppresses accesses
// - no_response_flag forces data bytes to 0xEE
package dcs_pkg;
	// ----------------------------------------------------------------
	// register field positions
	// ----------------------------------------------------------------
	localparam int HI_ENABLE   = 7;
	localparam int HI_ACTIVE   = 6;
	localparam int HI_CIS      = 5;
	localparam int HI_STEAL    = 3;
	localparam int HI_SERIAL_CLOCK_SOURCE_SELECT    = 2;
	localparam int HI_UNSECURED_STATUS    = 1;
	localparam int HI_ERASE    = 0;
	localparam int LO_WAIT     = 7;
	localparam int LO_STOP     = 6;
	localparam int LO_RAM_WRITE_FAULT_FLAG    = 5;
	localparam int LO_HOST_OVERRUN_FLAG    = 4;
	localparam int LO_NO_RESPONSE_FLAG   = 3;
	localparam int LO_ILLEGAL_COMMAND_FLAG   = 2;
	localparam int LO_SPARE    = 1;
	localparam int LO_SPARE0   = 0;
	// ----------------------------------------------------------------
	// values
	// ----------------------------------------------------------------
	localparam logic [7:0] NO_RESPONSE_FLAG_BYTE   = 8'hEE;
	localparam logic [7:0] HI_WR_MASK    = 8'hAC;  // bits 7,5,3,2
	localparam logic [7:0] LO_W1C_MASK   = 8'hEF;  // all but bit 4
	localparam int         STEAL_TIMEOUT = 512;
	localparam int         SERIAL_CLOCK_SOURCE_SELECT_WAIT    = 150;
	// ----------------------------------------------------------------
	// acknowledge length state
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		DCS_ACK_NORMAL  = 2'b00,
		DCS_ACK_LONG    = 2'b01,
		DCS_ACK_DEFER   = 2'b11
	} dcs_ack_t;
endpackage

//--- core/dcs_lowflags.sv
// sticky flag bank of the low status register
`timescale 1ns/100ps
module dcs_lowflags
	import dcs_pkg::*;
#(
	parameter int W = 8
)
(
	input  wire logic         ref_clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] set_ev,      // hardware set events
	input  wire logic [W-1:0] clr_req,     // write-one clear requests
	input  wire logic [W-1:0] clr_block,   // clear not allowed now
	output logic      [W-1:0] flags
);
	logic [W-1:0] next_flags;  // next flag values

	// set wins over clear in the same cycle
	always_comb
	begin
		next_flags = (flags & ~(clr_req & ~clr_block)) | set_ev;
	end

	// register the flags
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			flags <= '0;
		else
			flags <= next_flags;
	end

	// any bit whose set event fires must read back set, whatever was cleared
	a_set_wins: assert property (@(posedge ref_clk) disable iff (!rst_b)
		|set_ev |=> ((flags & $past(set_ev)) == $past(set_ev)))
		else $error("set lost to clear");
endmodule

//--- core/dcs_regs.sv
// control and status register pair of the background debug controller
`timescale 1ns/100ps
module dcs_regs
	import dcs_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	input  wire logic       special_single_chip,  // mode strap, sampled at release
	input  wire logic       soft_reset,           // soft reset pulse
	input  wire logic       hi_wr,                // write high register command
	input  wire logic       lo_wr,                // write low register command
	input  wire logic [7:0] wr_data,              // command data byte
	input  wire logic       bdm_enter,            // entering background mode
	input  wire logic       bdm_exit,             // exit sequence
	input  wire logic       in_stop,              // device in stop mode
	input  wire logic       stop_request,         // cpu requests stop
	input  wire logic       in_wait,              // device in wait mode
	input  wire logic       wait_enter,           // entering wait mode
	input  wire logic       secure,               // device secured
	input  wire logic       erase_cmd,            // mass erase command
	input  wire logic       erase_done,           // mass erase sequence done
	input  wire logic       ram_dfault,           // ecc double fault on debug write
	input  wire logic       early_cmd,            // command before previous done
	input  wire logic       pin_overrun,          // host low during pending ack
	input  wire logic       byte_received,        // whole byte after overrun edge
	input  wire logic       sync_pulse,           // host sync pulse
	input  wire logic       no_response_flag_ev,            // access did not complete
	input  wire logic       illegal_command_flag_ev,            // illegal command, other cause
	input  wire logic       illegal_command_flag_unimpl,        // unimplemented opcode
	input  wire logic       ack_enabled,          // acknowledge handshake on
	input  wire logic       ack_now,              // acknowledge being issued
	input  wire logic       cmd_failed,           // current command not executed right
	input  wire logic [7:0] access_data,          // raw data byte of access
	output logic      [7:0] ctrl_high,            // high register read value
	output logic      [7:0] ctrl_low,             // low register read value
	output logic      [7:0] access_out,           // data byte returned to host
	output logic            bdm_allowed,          // background mode may be entered
	output logic            restricted_cmds,      // restricted command set only
	output logic            keep_serial_clock,    // keep serial clock in stop
	output logic            keep_all_clocks,      // keep all clocks in stop
	output logic            steal_next_cycle,     // accesses take next bus cycle
	output logic            fast_clock_select,    // serial clock from fast clock
	output logic            access_suppress,      // internal accesses suppressed
	output logic            long_ack              // current acknowledge is long
);
	// ----------------------------------------------------------------
	// high register state
	// ----------------------------------------------------------------
	logic enable, next_enable;      // debug_enable
	logic active, next_active;      // debug_mode_active
	logic cis, next_cis;            // continue_in_stop
	logic steal, next_steal;        // immediate access select
	logic serial_clock_source_select, next_serial_clock_source_select;        // serial_clock_source_select
	logic erase, next_erase;        // mass erase pending
	logic strap_done, next_strap_done;  // strap sampled once after release
	logic [7:0] lo_flags;           // w1c flag bank
	logic host_overrun_flag, next_host_overrun_flag;        // host_overrun_flag
	dcs_ack_t ack_st, next_ack_st;  // acknowledge length tracking
	logic [7:0] lo_set, lo_clr, lo_blk;
	logic [1:0] ws_seen, next_ws_seen;  // wait, stop long ack already given

	// next values of the high register
	always_comb
	begin
		next_strap_done = 1'b1;
		next_enable = enable;
		next_active = active;
		next_cis    = cis;
		next_steal  = steal;
		next_serial_clock_source_select  = serial_clock_source_select;
		next_erase  = erase;
		// strap caught by a clocked process after release, not in reset
		if (!strap_done && special_single_chip)
		begin
			next_enable = 1'b1;
			next_active = 1'b1;
		end
		if (hi_wr)
		begin
			next_enable = wr_data[HI_ENABLE];
			next_steal  = wr_data[HI_STEAL];
			if (!in_stop)
				next_cis = wr_data[HI_CIS];
			if (wr_data[HI_SERIAL_CLOCK_SOURCE_SELECT])
				next_serial_clock_source_select = 1'b1;
		end
		// bit 6 is hardware only; exit clears, entry sets and wins
		if (bdm_exit)
			next_active = 1'b0;
		if (bdm_enter && next_enable)
			next_active = 1'b1;
		// erase pending: set only by command, set wins over completion
		if (erase_done || soft_reset)
			next_erase = 1'b0;
		if (erase_cmd)
			next_erase = 1'b1;
	end

	// register the high register
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			strap_done <= 1'b0;
			enable     <= 1'b0;
			active     <= 1'b0;
			cis        <= 1'b0;
			steal      <= 1'b0;
			serial_clock_source_select      <= 1'b0;
			erase      <= 1'b0;
		end
		else
		begin
			strap_done <= next_strap_done;
			enable     <= next_enable;
			active     <= next_active;
			cis        <= next_cis;
			steal      <= next_steal;
			serial_clock_source_select      <= next_serial_clock_source_select;
			erase      <= next_erase;
		end
	end

	// ----------------------------------------------------------------
	// low register flags
	// ----------------------------------------------------------------
	// set and clear terms per bit; bit 4 lives outside the bank
	always_comb
	begin
		lo_set = 8'h00;
		lo_set[LO_WAIT]   = wait_enter;
		lo_set[LO_STOP]   = stop_request & enable;
		lo_set[LO_RAM_WRITE_FAULT_FLAG]  = ram_dfault;
		lo_set[LO_NO_RESPONSE_FLAG] = no_response_flag_ev;
		lo_set[LO_ILLEGAL_COMMAND_FLAG] = illegal_command_flag_ev | illegal_command_flag_unimpl;
		lo_clr = lo_wr ? (wr_data & LO_W1C_MASK) : 8'h00;
		lo_blk = 8'h00;
		lo_blk[LO_WAIT] = in_wait;
		lo_blk[LO_STOP] = in_stop;
		lo_blk[LO_HOST_OVERRUN_FLAG] = 1'b1;
	end

	dcs_lowflags #(.W(8)) u_flags
	(
		.ref_clk   (ref_clk),
		.rst_b     (rst_b),
		.set_ev    (lo_set),
		.clr_req   (lo_clr),
		.clr_block (lo_blk),
		.flags     (lo_flags)
	);

	// overrun: set by early command or pin overrun, only sync clears
	always_comb
	begin
		next_host_overrun_flag = host_overrun_flag;
		if (sync_pulse)
			next_host_overrun_flag = 1'b0;
		if (early_cmd || pin_overrun)
			next_host_overrun_flag = 1'b1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			host_overrun_flag <= 1'b0;
		else
			host_overrun_flag <= next_host_overrun_flag;
	end

	// ----------------------------------------------------------------
	// acknowledge length
	// ----------------------------------------------------------------
	// a pin overrun defers the long pulse until a whole byte arrives
	always_comb
	begin
		next_ack_st  = ack_st;
		next_ws_seen = ws_seen;
		if (!lo_flags[LO_WAIT])
			next_ws_seen[0] = 1'b0;
		if (!lo_flags[LO_STOP])
			next_ws_seen[1] = 1'b0;
		case (ack_st)
			DCS_ACK_NORMAL:
				if (pin_overrun)
					next_ack_st = DCS_ACK_DEFER;
			DCS_ACK_DEFER:
				if (byte_received)
					next_ack_st = DCS_ACK_LONG;
			DCS_ACK_LONG:
				if (sync_pulse)
					next_ack_st = DCS_ACK_NORMAL;
			default:
				next_ack_st = DCS_ACK_NORMAL;
		endcase
		if (ack_now && ack_enabled)
		begin
			if (lo_flags[LO_WAIT])
				next_ws_seen[0] = 1'b1;
			if (lo_flags[LO_STOP])
				next_ws_seen[1] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			ack_st  <= DCS_ACK_NORMAL;
			ws_seen <= 2'b00;
		end
		else
		begin
			ack_st  <= next_ack_st;
			ws_seen <= next_ws_seen;
		end
	end

	// long when this command sets no_response_flag or the illegal flag, or fails; unimplemented opcode excluded
	always_comb
	begin
		long_ack = 1'b0;
		if (ack_enabled && ack_now)
		begin
			if (no_response_flag_ev || illegal_command_flag_ev || cmd_failed)
				long_ack = 1'b1;
			if (lo_flags[LO_WAIT] && !ws_seen[0])
				long_ack = 1'b1;
			if (lo_flags[LO_STOP] && !ws_seen[1])
				long_ack = 1'b1;
			if (ack_st == DCS_ACK_LONG || (host_overrun_flag && ack_st == DCS_ACK_NORMAL))
				long_ack = 1'b1;
			if (illegal_command_flag_unimpl && !illegal_command_flag_ev)
				long_ack = 1'b0;
			if (ack_st == DCS_ACK_DEFER)
				long_ack = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// read values and control outputs
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			ctrl_high  <= 8'h00;
			ctrl_low   <= 8'h00;
			access_out <= 8'h00;
		end
		else
		begin
			// bit 4 of high always zero
			ctrl_high <= {next_enable, next_active, next_cis, 1'b0, next_steal,
				next_serial_clock_source_select, ~secure, next_erase};
			ctrl_low  <= {lo_flags[7:5], host_overrun_flag, lo_flags[3:0]};
			access_out <= lo_flags[LO_NO_RESPONSE_FLAG] ? NO_RESPONSE_FLAG_BYTE : access_data;
		end
	end

	assign bdm_allowed       = enable;
	assign restricted_cmds   = ~enable;
	assign keep_serial_clock = enable & in_stop;
	assign keep_all_clocks   = enable & cis & in_stop;
	assign steal_next_cycle  = steal | ~ack_enabled;
	assign fast_clock_select = serial_clock_source_select;
	assign access_suppress   = host_overrun_flag;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_serial_clock_source_select_set;
		serial_clock_source_select;
	endsequence
	a_serial_clock_source_select_sticky: assert property (@(posedge ref_clk) disable iff (!rst_b)
		s_serial_clock_source_select_set |=> serial_clock_source_select) else $error("clock switch cleared");
	a_cis_frozen: assert property (@(posedge ref_clk) disable iff (!rst_b)
		in_stop |=> $stable(cis)) else $error("cis changed in stop");
	a_host_overrun_flag_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
		host_overrun_flag && !sync_pulse |=> host_overrun_flag) else $error("overrun lost");
	a_wait_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
		lo_flags[LO_WAIT] && in_wait |=> lo_flags[LO_WAIT]) else $error("wait cleared");
	a_stop_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!lo_flags[LO_STOP] && !enable |=> !lo_flags[LO_STOP]) else $error("stop set");
	a_no_response_flag_byte: assert property (@(posedge ref_clk) disable iff (!rst_b)
		lo_flags[LO_NO_RESPONSE_FLAG] |=> access_out == NO_RESPONSE_FLAG_BYTE) else $error("no 0xEE");
	a_erase_set: assert property (@(posedge ref_clk) disable iff (!rst_b)
		erase_cmd |=> ctrl_high[HI_ERASE]) else $error("erase not set");
	a_defer_short: assert property (@(posedge ref_clk) disable iff (!rst_b)
		ack_st == DCS_ACK_DEFER |-> !long_ack) else $error("long ack during defer");
	a_unsecured_status_bit: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!secure ##1 !secure |-> ctrl_high[HI_UNSECURED_STATUS]) else $error("unsecured_status wrong");
endmodule

//--- verification/dcs_host.sv
// host model: the serial command side of the single wire debug pin
`timescale 1ns/100ps
module dcs_host
	import dcs_pkg::*;
(
	input  wire logic       ref_clk,
	output logic            hi_wr,
	output logic            lo_wr,
	output logic      [7:0] wr_data,
	output logic      [3:0] link_ev
);
	// link_ev: 0 sync, 1 early command, 2 pin overrun, 3 byte received
	initial
	begin
		hi_wr = 1'b0;
		lo_wr = 1'b0;
		wr_data = 8'h00;
		link_ev = 4'h0;
	end
	// one write command; the data line shows the inverse once released
	task automatic wr(input logic hi, input logic [7:0] d);
		@(posedge ref_clk);
		hi_wr <= hi;
		lo_wr <= !hi;
		wr_data <= d;
		@(posedge ref_clk);
		hi_wr <= 1'b0;
		lo_wr <= 1'b0;
		wr_data <= ~d;
		// the new serial clock must settle before the next command
		if (hi && d[HI_SERIAL_CLOCK_SOURCE_SELECT])
			repeat (SERIAL_CLOCK_SOURCE_SELECT_WAIT) @(posedge ref_clk);
	endtask
	// one-cycle link event; a sync is the only way out of overrun
	task automatic lk(input int i);
		@(posedge ref_clk);
		link_ev[i] <= 1'b1;
		@(posedge ref_clk);
		link_ev[i] <= 1'b0;
	endtask
endmodule

//--- verification/tb_top.sv
// self-checking bench of the debug control and status register pair
`timescale 1ns/100ps
module tb_top
	import dcs_pkg::*;
;
	typedef struct {int k; logic [7:0] e;} dcs_note_t;
	logic        ref_clk;
	logic        rst_b;
	logic [4:0]  lv;           // strap, in_stop, in_wait, secure, ack_enabled
	logic [12:0] ev;           // device side one-cycle events
	logic [7:0]  access_data;  // raw access byte
	logic        hi_wr;
	logic        lo_wr;
	logic [7:0]  wr_data;
	logic [3:0]  link_ev;
	logic [7:0]  ctrl_high;
	logic [7:0]  ctrl_low;
	logic [7:0]  access_out;
	logic        bdm_allowed, restricted_cmds, keep_serial_clock, keep_all_clocks;
	logic        steal_next_cycle, fast_clock_select, access_suppress, long_ack;
	int          seed = 32'h2d1e;
	int          fails = 0;
	int          compares = 0;
	dcs_note_t   q[$];         // expected results, oldest first
	dcs_note_t   n;
	dcs_host i_dcs_host (.ref_clk(ref_clk), .hi_wr(hi_wr), .lo_wr(lo_wr),
		.wr_data(wr_data), .link_ev(link_ev));
	dcs_regs i_dcs_regs (.ref_clk(ref_clk), .rst_b(rst_b), .special_single_chip(lv[4]),
		.soft_reset(ev[0]), .hi_wr(hi_wr), .lo_wr(lo_wr), .wr_data(wr_data),
		.bdm_enter(ev[1]), .bdm_exit(ev[2]), .in_stop(lv[3]), .stop_request(ev[3]),
		.in_wait(lv[2]), .wait_enter(ev[4]), .secure(lv[1]), .erase_cmd(ev[5]),
		.erase_done(ev[6]), .ram_dfault(ev[7]), .early_cmd(link_ev[1]),
		.pin_overrun(link_ev[2]), .byte_received(link_ev[3]), .sync_pulse(link_ev[0]),
		.no_response_flag_ev(ev[8]), .illegal_command_flag_ev(ev[9]), .illegal_command_flag_unimpl(ev[10]),
		.ack_enabled(lv[0]), .ack_now(ev[11]), .cmd_failed(ev[12]),
		.access_data(access_data), .ctrl_high(ctrl_high), .ctrl_low(ctrl_low),
		.access_out(access_out), .bdm_allowed(bdm_allowed),
		.restricted_cmds(restricted_cmds), .keep_serial_clock(keep_serial_clock),
		.keep_all_clocks(keep_all_clocks), .steal_next_cycle(steal_next_cycle),
		.fast_clock_select(fast_clock_select), .access_suppress(access_suppress),
		.long_ack(long_ack));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// 125 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	task automatic cmp_byte(input string s, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic cmp_bit(input string s, input logic e, input logic g);
		compares++;
		if (g !== e)
		begin
			fails++;
			$display("[ERR] %s expected %b seen %b", s, e, g);
		end
	endtask
	task automatic conclude();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// note an expectation at the falling edge, where outputs have settled
	task automatic ck(input int k, input logic [7:0] e);
		@(negedge ref_clk);
		q.push_back('{k, e});
	endtask
	// registered outputs lag their cause by two edges; three is safe
	task automatic rd(input int k, input logic [7:0] e);
		repeat (3) @(posedge ref_clk);
		ck(k, e);
	endtask
	// one-cycle device events, optionally judged while they stand
	task automatic go(input logic [12:0] m, input int k, input logic [7:0] e);
		@(posedge ref_clk);
		ev <= m;
		if (k >= 0)
			ck(k, e);
		@(posedge ref_clk);
		ev <= '0;
	endtask
	task automatic lvl(input int i, input logic v);
		@(posedge ref_clk);
		lv[i] <= v;
	endtask
	// monitor: every noted result is compared a little after the falling edge
	initial
	forever
	begin
		@(negedge ref_clk);
		#1;
		while (q.size() > 0)
		begin
			n = q.pop_front();
			case (n.k)
				0: cmp_byte("ctrl_high", n.e, ctrl_high);
				1: cmp_byte("ctrl_low", n.e, ctrl_low);
				2: cmp_byte("access_out", n.e, access_out);
				3: cmp_bit("long_ack", n.e[0], long_ack);
				4: cmp_byte("levels", n.e, {2'b00, bdm_allowed, restricted_cmds,
					keep_all_clocks, steal_next_cycle, fast_clock_select, access_suppress});
				default: cmp_bit("keep_serial_clock", n.e[0], keep_serial_clock);
			endcase
		end
	end
	// watchdog: the whole sequence needs about five hundred cycles
	initial
	begin
		repeat (4000) @(posedge ref_clk);
		fails++;
		conclude();
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		rst_b = 1'b0;
		lv = 5'b10000;
		ev = '0;
		access_data = 8'h00;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		rd(0, 8'hC2);
		rd(4, 8'h24);
		rd(5, 8'h00);
		i_dcs_host.wr(1'b1, 8'hFF);
		rd(0, 8'hEE);
		rd(4, 8'h26);
		lvl(0, 1'b1);
		i_dcs_host.wr(1'b1, 8'h00);
		rd(0, 8'h46);
		rd(4, 8'h12);
		rd(5, 8'h00);
		lvl(0, 1'b0);
		rd(4, 8'h16);
		lvl(3, 1'b1);
		i_dcs_host.wr(1'b1, 8'hA0);
		rd(0, 8'hC6);
		rd(5, 8'h01);
		lvl(3, 1'b0);
		go(13'h0004, -1, 8'h00);
		rd(0, 8'h86);
		go(13'h0002, -1, 8'h00);
		rd(0, 8'hC6);
		lvl(1, 1'b1);
		rd(0, 8'hC4);
		lvl(1, 1'b0);
		go(13'h0020, -1, 8'h00);
		i_dcs_host.wr(1'b1, 8'h84);
		rd(0, 8'hC7);
		go(13'h0040, -1, 8'h00);
		rd(0, 8'hC6);
		// a soft reset also drops a pending erase
		go(13'h0020, -1, 8'h00);
		rd(0, 8'hC7);
		go(13'h0001, -1, 8'h00);
		rd(0, 8'hC6);
		// sticky flags of the low register
		lvl(2, 1'b1);
		go(13'h0010, -1, 8'h00);
		i_dcs_host.wr(1'b0, 8'h80);
		rd(1, 8'h80);
		lvl(2, 1'b0);
		i_dcs_host.wr(1'b0, 8'h80);
		rd(1, 8'h00);
		lvl(3, 1'b1);
		go(13'h0008, -1, 8'h00);
		i_dcs_host.wr(1'b0, 8'hFF);
		rd(1, 8'h40);
		lvl(3, 1'b0);
		i_dcs_host.wr(1'b0, 8'h40);
		rd(1, 8'h00);
		go(13'h0080, -1, 8'h00);
		i_dcs_host.wr(1'b0, 8'h00);
		rd(1, 8'h20);
		i_dcs_host.wr(1'b0, 8'h20);
		rd(1, 8'h00);
		@(posedge ref_clk);
		access_data <= 8'($random(seed));
		go(13'h0100, -1, 8'h00);
		rd(2, 8'hEE);
		i_dcs_host.wr(1'b0, 8'h08);
		rd(2, access_data);
		i_dcs_host.lk(1);
		rd(4, 8'h27);
		i_dcs_host.wr(1'b0, 8'hFF);
		rd(1, 8'h10);
		i_dcs_host.lk(0);
		rd(1, 8'h00);
		// acknowledge length
		lvl(0, 1'b1);
		go(13'h0800, 3, 8'h00);
		go(13'h1800, 3, 8'h01);
		go(13'h0900, 3, 8'h01);
		go(13'h0800, 3, 8'h00);
		go(13'h0C00, 3, 8'h00);
		go(13'h0A00, 3, 8'h01);
		lvl(2, 1'b1);
		go(13'h0010, -1, 8'h00);
		go(13'h0800, 3, 8'h01);
		go(13'h0800, 3, 8'h00);
		lvl(2, 1'b0);
		i_dcs_host.lk(2);
		go(13'h0800, 3, 8'h00);
		i_dcs_host.lk(3);
		go(13'h0800, 3, 8'h01);
		go(13'h0800, 3, 8'h01);
		i_dcs_host.lk(0);
		go(13'h0800, 3, 8'h00);
		// second reset, strap low this time
		@(posedge ref_clk);
		rst_b <= 1'b0;
		lv[4] <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		rd(0, 8'h02);
		rd(1, 8'h00);
		rd(4, 8'h10);
		repeat (3) @(posedge ref_clk);
		conclude();
	end
endmodule
